/* File: hdl/pmp_cfg.svh */
// Timing counts and field positions for the MAC-side pin block
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH
`define PMP_CLK_MHZ        125
`define PMP_RST_MIN_US     25
`define PMP_RST_MIN_CYC    (`PMP_RST_MIN_US * `PMP_CLK_MHZ)
`define PMP_DIV100_HALF    20'h00005
`define PMP_DIV10_HALF     20'h00032
`define PMP_BLINK_HALF     24'h2faf08
`define PMP_STRAP_W        5
`define PMP_STRAP_COL      0
`define PMP_STRAP_CRS      1
`define PMP_STRAP_LNK      2
`define PMP_STRAP_SPD      3
`define PMP_STRAP_RXDV     4
`endif

/* File: hdl/pmp_pkg.sv */
// Types shared by both ends of the MAC-side pin link
`default_nettype none
package pmp_pkg;
	typedef enum logic {PMP_MII, PMP_RMII} pmp_mode_t;
	typedef enum logic {PMP_SPD10, PMP_SPD100} pmp_speed_t;
	typedef enum logic [1:0] {PMP_IN_RESET, PMP_STRAP, PMP_RUN} pmp_state_t;
endpackage
`default_nettype wire

/* File: hdl/pmp_link_if.sv */
// Pin bundle between the PHY end and the MAC end
`default_nettype none
interface pmp_link_if;
	logic       tx_clk;
	logic       tx_en;
	logic [3:0] tx_d;
	logic       tx_er;
	logic       col;
	logic       col_oe_n;
	logic       crs;
	logic       crs_oe_n;
	logic       rx_dv;
	logic       rst_n;
	modport phy (output tx_clk, col, col_oe_n, crs, crs_oe_n, rx_dv,
		input tx_en, tx_d, tx_er, rst_n);
	modport mac (input tx_clk, col, col_oe_n, crs, crs_oe_n, rx_dv,
		output tx_en, tx_d, tx_er, rst_n);
endinterface
`default_nettype wire

/* File: hdl/pmp_mac_end.sv */
// MAC end: drives transmit enable, data and the active-low reset
`include "pmp_cfg.svh"
`default_nettype none
module pmp_mac_end
	import pmp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       ce,
	// User side
	input  wire logic       mode_rmii,
	input  wire logic       phy_reset_req,
	input  wire logic       tx_valid,
	input  wire logic [3:0] tx_data,
	input  wire logic       tx_error,
	output logic            tx_taken,
	output logic            phy_in_reset,
	output logic            col_seen,
	output logic            crs_seen,
	// Link
	pmp_link_if.mac         link
);
	logic [2:0]  clk_s_q, clk_s_d;
	logic [1:0]  col_s_q, col_s_d, crs_s_q, crs_s_d;
	logic        en_q, en_d, er_q, er_d, rst_n_q, rst_n_d, taken_q, taken_d;
	logic        prst_q, prst_d;
	logic [3:0]  d_q, d_d;
	logic [15:0] rcnt_q, rcnt_d;
	logic        edge_r;

	always_comb begin
		clk_s_d = {clk_s_q[1:0], link.tx_clk};
		col_s_d = {col_s_q[0], link.col};
		crs_s_d = {crs_s_q[0], link.crs};
		edge_r  = clk_s_q[1] & ~clk_s_q[2];
		en_d    = en_q;
		d_d     = d_q;
		er_d    = er_q;
		taken_d = 1'b0;
		rst_n_d = rst_n_q;
		rcnt_d  = rcnt_q;
		// Hold reset low for the full minimum time before releasing
		if (phy_reset_req) begin
			rst_n_d = 1'b0;
			rcnt_d  = 16'h0000;
		end else if (!rst_n_q) begin
			if (rcnt_q >= 16'(`PMP_RST_MIN_CYC - 1))
				rst_n_d = 1'b1;
			else
				rcnt_d = rcnt_q + 16'h0001;
		end
		// Registered copy so the status output comes from a flop
		prst_d = ~rst_n_d;
		// MII: launch on sampled rising edge of the PHY's clock
		// RMII: this clock domain stands in for the shared reference
		if (rst_n_q && (mode_rmii || edge_r)) begin
			en_d    = tx_valid;
			d_d     = mode_rmii ? {2'b00, tx_data[1:0]} : tx_data;
			er_d    = tx_error;
			taken_d = tx_valid;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			clk_s_q <= 3'h0;
			col_s_q <= 2'h0;
			crs_s_q <= 2'h0;
			en_q    <= 1'b0;
			d_q     <= 4'h0;
			er_q    <= 1'b0;
			taken_q <= 1'b0;
			rst_n_q <= 1'b0;
			prst_q  <= 1'b1;
			rcnt_q  <= 16'h0000;
		end else if (ce) begin
			clk_s_q <= clk_s_d;
			col_s_q <= col_s_d;
			crs_s_q <= crs_s_d;
			en_q    <= en_d;
			d_q     <= d_d;
			er_q    <= er_d;
			taken_q <= taken_d;
			rst_n_q <= rst_n_d;
			prst_q  <= prst_d;
			rcnt_q  <= rcnt_d;
		end
	end

	assign link.tx_en = en_q;
	assign link.tx_d  = d_q;
	assign link.tx_er = er_q;
	assign link.rst_n = rst_n_q;
	assign tx_taken     = taken_q;
	assign phy_in_reset = prst_q;
	assign col_seen     = col_s_q[1];
	assign crs_seen     = crs_s_q[1];
endmodule
`default_nettype wire

/* File: hdl/pmp_phy_end.sv */
// PHY end: MAC-facing transmit pins, collision, carrier, indicators, reset
// Overview of operation
// - Sample transmit enable on transmit clock rise
// - Data valid: four bits MII, two RMII
// - MAC launches MII nibble on transmit clock
// - MAC launches RMII dibit on reference clock
// - Full duplex MII: collision always low
// - Half duplex MII: collision when both media busy
// - MII carrier sense when either medium busy
// - Link indicator lit on link, blinks activity
// - Both indicators fixed active low
// - Speed indicator lit only at 100M
// - Speed pin may become transmit error input
// - Reset low at least 25 us
// - Reset re-samples straps, defaults all state; tx_out_data and tx_out_error keep their values
// - Transmit clock 25 or 2.5 MHz, not RMII; divider gives 12.5 or 1.25 MHz
// - RMII receive valid carries carrier sense
`include "pmp_cfg.svh"
`default_nettype none
module pmp_phy_end
	import pmp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                    core_clk,
	input  wire logic                    srst,
	input  wire logic                    ce,
	// Link state from the media side
	input  wire logic                    mode_rmii,
	input  wire logic                    full_duplex,
	input  wire logic                    link_up,
	input  wire logic                    speed_100,
	input  wire logic                    rx_busy,
	input  wire logic                    rx_valid,
	input  wire logic                    spd_pin_is_txer,
	// Strap levels seen on shared pins
	input  wire logic [`PMP_STRAP_W-1:0] strap_pins,
	// Data toward the media side
	output logic                         tx_out_valid,
	output logic [3:0]                   tx_out_data,
	output logic                         tx_out_error,
	output logic [`PMP_STRAP_W-1:0]      strap_q,
	output logic                         in_reset,
	// Indicators, active low
	output logic                         link_activity_indicator_n,
	output logic                         speed_indicator_n,
	output logic                         speed_indicator_oe_n,
	// Link
	pmp_link_if.phy                      link
);
	pmp_state_t                st_q, st_d;
	logic [1:0]                rst_s_q, rst_s_d, en_s_q, en_s_d, er_s_q, er_s_d;
	logic [3:0]                d_s0_q, d_s0_d, d_s1_q, d_s1_d;
	logic [1:0]                mode_s_q, mode_s_d;
	logic [`PMP_STRAP_W-1:0]   strap_s0_q, strap_s0_d, strap_s1_q, strap_s1_d, strap_d;
	logic [15:0]               rcnt_q, rcnt_d;
	logic [19:0]               div_q, div_d;
	logic                      tclk_q, tclk_d;
	logic [23:0]               blink_cnt_q, blink_cnt_d;
	logic                      blink_q, blink_d;
	logic                      v_q, v_d, e_q, e_d, col_q, col_d, crs_q, crs_d;
	logic                      dv_q, dv_d, lnk_q, lnk_d, spd_q, spd_d, spd_oe_q, spd_oe_d;
	logic [3:0]                dat_q, dat_d;
	logic                      idle_q, idle_d;
	logic                      run;

	always_comb begin
		rst_s_d    = {rst_s_q[0], link.rst_n};
		en_s_d     = {en_s_q[0], link.tx_en};
		er_s_d     = {er_s_q[0], link.tx_er};
		d_s0_d     = link.tx_d;
		d_s1_d     = d_s0_q;
		strap_s0_d = strap_pins;
		strap_s1_d = strap_s0_q;
		mode_s_d   = {mode_s_q[0], mode_rmii};
		st_d       = st_q;
		rcnt_d     = rcnt_q;
		strap_d    = strap_q;
		// Low pulse must last the minimum before the reset takes hold
		if (!rst_s_q[1]) begin
			if (rcnt_q >= 16'(`PMP_RST_MIN_CYC - 1))
				st_d = PMP_IN_RESET;
			else
				rcnt_d = rcnt_q + 16'h0001;
		end else begin
			rcnt_d = 16'h0000;
		end
		case (st_q)
			PMP_IN_RESET: if (rst_s_q[1]) st_d = PMP_STRAP;
			PMP_STRAP: begin
				strap_d = strap_s1_q;
				st_d    = PMP_RUN;
			end
			default: ;
		endcase
		// Taken from the next state so the registered flag keeps the state's timing
		idle_d = (st_d != PMP_RUN);
	end
	assign run = (st_q == PMP_RUN);

	// Transmit clock divider, stopped in RMII mode
	always_comb begin
		div_d  = div_q;
		tclk_d = 1'b0;
		if (run && !mode_s_q[1]) begin
			tclk_d = tclk_q;
			if (div_q >= (speed_100 ? `PMP_DIV100_HALF : `PMP_DIV10_HALF) - 20'h00001) begin
				div_d  = 20'h00000;
				tclk_d = ~tclk_q;
			end else begin
				div_d = div_q + 20'h00001;
			end
		end else begin
			div_d = 20'h00000;
		end
	end

	// Activity blink, period fixed by the core clock since no rate is given
	always_comb begin
		blink_cnt_d = blink_cnt_q;
		blink_d     = blink_q;
		if (run && (rx_busy || v_q)) begin
			if (blink_cnt_q >= `PMP_BLINK_HALF - 24'h000001) begin
				blink_cnt_d = 24'h000000;
				blink_d     = ~blink_q;
			end else begin
				blink_cnt_d = blink_cnt_q + 24'h000001;
			end
		end else begin
			blink_cnt_d = 24'h000000;
			blink_d     = 1'b0;
		end
	end

	always_comb begin
		v_d      = 1'b0;
		dat_d    = dat_q;
		e_d      = e_q;
		col_d    = 1'b0;
		crs_d    = 1'b0;
		dv_d     = 1'b0;
		lnk_d    = 1'b1;
		spd_d    = 1'b1;
		spd_oe_d = 1'b1;
		if (run) begin
			// Internal rise of the generated clock is its pin edge
			if (mode_s_q[1] || (!tclk_q && tclk_d)) begin
				v_d   = en_s_q[1];
				dat_d = mode_s_q[1] ? {2'b00, d_s1_q[1:0]} : d_s1_q;
				e_d   = spd_pin_is_txer & er_s_q[1];
			end else begin
				v_d = v_q;
			end
			if (!mode_s_q[1]) begin
				col_d = !full_duplex && rx_busy && v_q;
				crs_d = rx_busy || v_q;
				dv_d  = rx_valid;
			end else begin
				dv_d = rx_busy || rx_valid;
			end
			lnk_d    = ~(link_up && !blink_q);
			spd_oe_d = spd_pin_is_txer;
			spd_d    = ~(link_up && speed_100);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= PMP_IN_RESET;
			{rst_s_q, en_s_q, er_s_q, mode_s_q} <= 8'h00;
			{d_s0_q, d_s1_q} <= 8'h00;
			{strap_s0_q, strap_s1_q, strap_q} <= '0;
			rcnt_q <= 16'h0000;
			div_q <= 20'h00000;
			tclk_q <= 1'b0;
			blink_cnt_q <= 24'h000000;
			blink_q <= 1'b0;
			{v_q, e_q, col_q, crs_q, dv_q} <= 5'h00;
			{lnk_q, spd_q, spd_oe_q} <= 3'h7;
			dat_q <= 4'h0;
			idle_q <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
			{rst_s_q, en_s_q, er_s_q, mode_s_q} <= {rst_s_d, en_s_d, er_s_d, mode_s_d};
			{d_s0_q, d_s1_q} <= {d_s0_d, d_s1_d};
			{strap_s0_q, strap_s1_q, strap_q} <= {strap_s0_d, strap_s1_d, strap_d};
			rcnt_q <= rcnt_d;
			div_q <= div_d;
			tclk_q <= tclk_d;
			blink_cnt_q <= blink_cnt_d;
			blink_q <= blink_d;
			{v_q, e_q, col_q, crs_q, dv_q} <= {v_d, e_d, col_d, crs_d, dv_d};
			{lnk_q, spd_q, spd_oe_q} <= {lnk_d, spd_d, spd_oe_d};
			dat_q <= dat_d;
			idle_q <= idle_d;
		end
	end

	assign link.tx_clk   = tclk_q;
	assign link.col      = col_q;
	assign link.col_oe_n = idle_q;
	assign link.crs      = crs_q;
	assign link.crs_oe_n = idle_q;
	assign link.rx_dv    = dv_q;
	assign tx_out_valid  = v_q;
	assign tx_out_data   = dat_q;
	assign tx_out_error  = e_q;
	assign in_reset      = idle_q;
	assign link_activity_indicator_n = lnk_q;
	assign speed_indicator_n         = spd_q;
	assign speed_indicator_oe_n      = spd_oe_q;
endmodule
`default_nettype wire

/* File: dv/pmp_link_checker.sv */
// Protocol checks on the pins between the PHY end and the MAC end
`default_nettype none
module pmp_link_checker (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Link pins
	input  wire logic tx_clk,
	input  wire logic col,
	input  wire logic col_oe_n,
	input  wire logic crs,
	input  wire logic crs_oe_n,
	input  wire logic rx_dv,
	input  wire logic rst_n
);
	// Counts cycles of reset low; srst clears it, as it restarts the MAC end's low time
	logic [15:0] low_q;
	logic [15:0] low_d;
	always_comb begin
		low_d = rst_n ? 16'h0000 : low_q + {15'h0000, ~&low_q};
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			low_q <= 16'h0000;
		end else begin
			low_q <= low_d;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_col_crs; col |-> crs; endproperty
	a_col_crs: assert property (p_col_crs) else $error("col without crs");
	property p_clk_high; $rose(tx_clk) |-> ##[1:50] !tx_clk; endproperty
	a_clk_high: assert property (p_clk_high) else $error("tx_clk high too long");
	property p_rst_min; $rose(rst_n) |-> low_q >= 16'h0c35; endproperty
	a_rst_min: assert property (p_rst_min) else $error("reset pulse short");
	property p_oe_srst; $fell(srst) |-> (col_oe_n && crs_oe_n)[*3]; endproperty
	a_oe_srst: assert property (p_oe_srst) else $error("pins driven in reset");
	property p_quiet_srst; $fell(srst) |-> (!col && !crs && !rx_dv && !tx_clk)[*3]; endproperty
	a_quiet_srst: assert property (p_quiet_srst) else $error("outputs active in reset");
	property p_held; low_q >= 16'h0c40 |-> col_oe_n && crs_oe_n && !tx_clk; endproperty
	a_held: assert property (p_held) else $error("long reset not taken");
	property p_release; $rose(rst_n) && low_q >= 16'h0c40 |-> (col_oe_n && crs_oe_n)[*2];
	endproperty
	a_release: assert property (p_release) else $error("pins driven at release");
	property p_col_idle; col_oe_n |-> !col; endproperty
	a_col_idle: assert property (p_col_idle) else $error("col high while released");
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench joining the PHY end and the MAC end
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, srst, mode_rmii, full_duplex, link_up, speed_100, rx_busy, rx_valid;
	logic spd_txer, phy_reset_req, tx_valid, tx_error, tx_out_valid, tx_out_error, in_reset;
	logic lnk_n, spd_n, spd_oe_n, phy_in_reset, col_seen, crs_seen, tx_taken;
	logic [3:0] tx_data, tx_out_data;
	logic [4:0] strap_pins, strap_q;
	int num_errors = 0;
	int samples_checked = 0;
	pmp_link_if u_pmp_link_if ();
	pmp_mac_end u_pmp_mac_end (.core_clk(core_clk), .srst(srst), .ce(1'b1),
		.mode_rmii(mode_rmii), .phy_reset_req(phy_reset_req), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_error(tx_error), .tx_taken(tx_taken),
		.phy_in_reset(phy_in_reset),
		.col_seen(col_seen), .crs_seen(crs_seen), .link(u_pmp_link_if.mac));
	pmp_phy_end u_pmp_phy_end (.core_clk(core_clk), .srst(srst), .ce(1'b1),
		.mode_rmii(mode_rmii), .full_duplex(full_duplex), .link_up(link_up),
		.speed_100(speed_100), .rx_busy(rx_busy), .rx_valid(rx_valid),
		.spd_pin_is_txer(spd_txer), .strap_pins(strap_pins), .tx_out_valid(tx_out_valid),
		.tx_out_data(tx_out_data), .tx_out_error(tx_out_error), .strap_q(strap_q),
		.in_reset(in_reset), .link_activity_indicator_n(lnk_n), .speed_indicator_n(spd_n),
		.speed_indicator_oe_n(spd_oe_n), .link(u_pmp_link_if.phy));
	pmp_link_checker u_pmp_link_checker (.core_clk(core_clk), .srst(srst),
		.tx_clk(u_pmp_link_if.tx_clk), .col(u_pmp_link_if.col),
		.col_oe_n(u_pmp_link_if.col_oe_n), .crs(u_pmp_link_if.crs),
		.crs_oe_n(u_pmp_link_if.crs_oe_n), .rx_dv(u_pmp_link_if.rx_dv),
		.rst_n(u_pmp_link_if.rst_n));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wait_run(input int n);
		for (int i = 0; i < n && in_reset !== 1'b0; i++) tick(1);
	endtask
	task automatic t_start;
		srst = 1'b1;
		tick(5);
		srst = 1'b0;
		wait_run(4000);
		chk("strap", 5'h15, strap_q);
		tick(4);
		chk("lnk_n", 5'h00, {4'h0, lnk_n});
		chk("spd_n", 5'h00, {4'h0, spd_n});
		chk("spd_oe_n", 5'h00, {4'h0, spd_oe_n});
	endtask
	task automatic t_ind;
		speed_100 = 1'b0;
		tick(4);
		chk("spd_n 10M", 5'h01, {4'h0, spd_n});
		link_up = 1'b0;
		tick(4);
		chk("lnk_n down", 5'h01, {4'h0, lnk_n});
		spd_txer = 1'b1;
		link_up = 1'b1;
		speed_100 = 1'b1;
		tick(4);
		chk("spd_oe_n txer", 5'h01, {4'h0, spd_oe_n});
	endtask
	task automatic t_mii;
		tx_valid = 1'b1;
		tx_data = 4'ha;
		tx_error = 1'b1;
		for (int i = 0; i < 200 && tx_out_valid !== 1'b1; i++) tick(1);
		tick(12);
		chk("tx valid", 5'h01, {4'h0, tx_out_valid});
		chk("tx data", 5'h0a, {1'b0, tx_out_data});
		chk("tx err", 5'h01, {4'h0, tx_out_error});
		rx_busy = 1'b1;
		tick(40);
		chk("col half", 5'h01, {4'h0, col_seen});
		full_duplex = 1'b1;
		tick(10);
		chk("col full", 5'h00, {4'h0, col_seen});
		tx_valid = 1'b0;
		tick(40);
		chk("tx idle", 5'h00, {4'h0, tx_out_valid});
		chk("taken idle", 5'h00, {4'h0, tx_taken});
		chk("crs rx", 5'h01, {4'h0, crs_seen});
		rx_busy = 1'b0;
		tick(10);
		chk("crs idle", 5'h00, {4'h0, crs_seen});
	endtask
	task automatic t_rmii;
		mode_rmii = 1'b1;
		tick(10);
		tx_valid = 1'b1;
		tx_data = 4'hf;
		rx_valid = 1'b1;
		tick(20);
		chk("rmii data", 5'h03, {1'b0, tx_out_data});
		chk("rmii taken", 5'h01, {4'h0, tx_taken});
		chk("rx_dv", 5'h01, {4'h0, u_pmp_link_if.rx_dv});
		chk("rmii crs", 5'h00, {4'h0, crs_seen});
		tx_valid = 1'b0;
		rx_valid = 1'b0;
		mode_rmii = 1'b0;
		tick(10);
	endtask
	task automatic t_prst;
		strap_pins = 5'h0a;
		phy_reset_req = 1'b1;
		tick(100);
		phy_reset_req = 1'b0;
		chk("mac rst", 5'h01, {4'h0, phy_in_reset});
		tick(3000);
		chk("too early", 5'h00, {4'h0, in_reset});
		tick(70);
		chk("in reset", 5'h01, {4'h0, in_reset});
		wait_run(300);
		chk("restrap", 5'h0a, strap_q);
		chk("mac out", 5'h00, {4'h0, phy_in_reset});
	endtask
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end
	initial begin
		{srst, mode_rmii, full_duplex, rx_busy, rx_valid, spd_txer} = '0;
		{phy_reset_req, tx_valid, tx_error} = '0;
		link_up = 1'b1;
		speed_100 = 1'b1;
		tx_data = 4'h0;
		strap_pins = 5'h15;
		t_start();
		t_ind();
		t_mii();
		t_rmii();
		t_prst();
		end_sim();
	end
endmodule
`default_nettype wire
